// *** shared/sfp_pkg.sv ***
// constants and rule overview for the serial flash page/buffer sequencer
// Overview of operation
// - opcode D2H, three address bytes, 32 dummy clocks, then data shifts out
// - address is reserved bit, 13-bit page number, 10-bit byte offset
// - page read wraps to byte zero of the same page
// - chip select rising ends reads and floats serial output
// - page read reaches any page, buffers untouched
// - D4H reads buffer 1, D6H reads buffer 2
// - buffer read: 14 ignored bits, 10-bit offset, one dummy byte
// - buffer read wraps after byte 527 to byte zero
// - 84H/87H buffer write, 10-bit start offset, data follows directly
// - buffer write increments and wraps; stops when chip select rises
// - 83H/86H erase page then program it from buffer
// - 88H/89H program page from buffer without erase
// - busy shown on status and ready/busy pin during self-timed work
// - 81H erases one page on chip select rising
// - 50H erases eight consecutive pages on chip select rising
// - block number is upper ten page bits; low three ignored
// - 82H/85H load chosen buffer from offset, wrapping at its end
// - 82H/85H then erase and program the page from the buffer
// - commands start with chip select low then an 8-bit opcode
// - all fields move most significant bit first
// - status bit 7 is one when ready, zero when busy
package sfp_pkg;
	localparam int CLK_MHZ = 10;
	localparam logic [7:0] OP_PAGE_RD = 8'hd2;
	localparam logic [7:0] OP_BUF1_RD = 8'hd4;
	localparam logic [7:0] OP_BUF2_RD = 8'hd6;
	localparam logic [7:0] OP_BUF1_WR = 8'h84;
	localparam logic [7:0] OP_BUF2_WR = 8'h87;
	localparam logic [7:0] OP_BUF1_EP = 8'h83;
	localparam logic [7:0] OP_BUF2_EP = 8'h86;
	localparam logic [7:0] OP_BUF1_PR = 8'h88;
	localparam logic [7:0] OP_BUF2_PR = 8'h89;
	localparam logic [7:0] OP_PAGE_ER = 8'h81;
	localparam logic [7:0] OP_BLOCK_ER = 8'h50;
	localparam logic [7:0] OP_BUF1_WP = 8'h82;
	localparam logic [7:0] OP_BUF2_WP = 8'h85;
	localparam logic [6:0] HDR_LAST = 7'd31;
	localparam logic [6:0] DATA_START = 7'd32;
	localparam logic [6:0] BUF_RD_START = 7'd40;
	localparam logic [6:0] PAGE_RD_START = 7'd64;
	localparam logic [6:0] CNT_LOOP_HI = 7'd71;
	localparam int PAGE_LSB = 10;
	localparam int PAGE_MSB = 22;
	localparam int BLOCK_LSB = 13;
	localparam int OFF_MSB = 9;
	localparam int BUF_BYTES = 528;
	localparam logic [9:0] LAST_OFF = 10'd527;
	localparam int STAT_RDY_BIT = 7;
	localparam int ERASE_PROG_TIME_US = 14000;
	localparam int PROG_ONLY_TIME_US = 3000;
	localparam int PAGE_ERASE_TIME_US = 8000;
	localparam int BLOCK_ERASE_TIME_US = 12000;
	localparam int ERASE_PROG_CYC = ERASE_PROG_TIME_US * CLK_MHZ;
	localparam int PROG_ONLY_CYC = PROG_ONLY_TIME_US * CLK_MHZ;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_MHZ;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_RUN = 2'b10
	} sfp_seq_type;
endpackage

// *** verilog/sfp_flash_seq.sv ***
// serial command decoder, page buffers and self-timed erase/program sequencer
`timescale 1ns/1ps
module sfp_flash_seq #(
	parameter int TMR_W = 20,
	parameter int ERASE_PROG_CYC = sfp_pkg::ERASE_PROG_CYC,
	parameter int PROG_ONLY_CYC = sfp_pkg::PROG_ONLY_CYC,
	parameter int PAGE_ERASE_CYC = sfp_pkg::PAGE_ERASE_CYC,
	parameter int BLOCK_ERASE_CYC = sfp_pkg::BLOCK_ERASE_CYC
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic sck,
	input wire logic csN,
	input wire logic si,
	output logic soOut,
	output logic soOeN,
	output logic rdyBusyN,
	output logic [7:0] statusByte,
	output logic [12:0] arrayRdPage,
	output logic [9:0] arrayRdOffset,
	input wire logic [7:0] arrayRdData,
	output logic arrayEraseStb,
	output logic arrayEraseBlock,
	output logic [12:0] arrayErasePage,
	output logic arrayProgValid,
	output logic [12:0] arrayProgPage,
	output logic [9:0] arrayProgOffset,
	output logic [7:0] arrayProgByte
);
	import sfp_pkg::*;

	// both 528-byte buffers; written only from the serial clock domain
	logic [7:0] bufMem [2][BUF_BYTES];

	logic [6:0] cnt_q;
	logic [30:0] hdr_q;
	logic [31:0] cmd_q;
	logic cmdTgl_q;
	logic [6:0] wsh_q;
	logic [9:0] wptr_q;
	logic busyS1_q, busyS2_q;
	logic busy_q, busyBuf_q;
	logic [9:0] rdPtr_q;
	logic rdStarted_q, soOut_q;
	logic [2:0] obit_q;
	logic [6:0] obyte_q;

	function automatic logic bufOf(input logic [7:0] op);
		bufOf = (op == OP_BUF2_RD) || (op == OP_BUF2_WR) || (op == OP_BUF2_EP)
			|| (op == OP_BUF2_PR) || (op == OP_BUF2_WP);
	endfunction

	logic [7:0] op;
	logic isWrite, isPageRd, isBufRd, rdActive, wrStb;
	logic [9:0] wAddr, rdOff;
	logic [7:0] rdByte;
	assign op = cmd_q[31:24];
	assign isWrite = (op == OP_BUF1_WR) || (op == OP_BUF2_WR)
		|| (op == OP_BUF1_WP) || (op == OP_BUF2_WP);
	assign isPageRd = (op == OP_PAGE_RD);
	assign isBufRd = (op == OP_BUF1_RD) || (op == OP_BUF2_RD);
	// reads start only after the dummy clocks have passed
	assign rdActive = (isPageRd && cnt_q >= PAGE_RD_START)
		|| (isBufRd && cnt_q >= BUF_RD_START);
	// first stored byte (eighth data edge) goes to the header's offset
	assign wAddr = (cnt_q == DATA_START + 7'd7) ? cmd_q[OFF_MSB:0]
		: wptr_q;
	// a write into the buffer that a running program reads is dropped
	assign wrStb = isWrite && cnt_q >= DATA_START && cnt_q[2:0] == 3'd7
		&& !(busyS2_q && busyBuf_q == bufOf(op));
	assign rdOff = rdStarted_q ? rdPtr_q : cmd_q[OFF_MSB:0];
	assign arrayRdPage = cmd_q[PAGE_MSB:PAGE_LSB];
	assign arrayRdOffset = rdOff;
	assign rdByte = isPageRd ? arrayRdData : bufMem[bufOf(op)][rdOff];

	// chip select high holds the bit counter in reset, framing each command
	always_ff @(posedge sck or posedge csN)
	begin
		if (csN)
			cnt_q <= 7'd0;
		else if (cnt_q == CNT_LOOP_HI)
			cnt_q <= PAGE_RD_START;
		else
			cnt_q <= cnt_q + 7'd1;
	end

	always_ff @(posedge sck)
	begin
		if (!csN && cnt_q < DATA_START)
			hdr_q <= {hdr_q[29:0], si};
		if (!csN && cnt_q == HDR_LAST)
			cmd_q <= {hdr_q, si};
		wsh_q <= {wsh_q[5:0], si};
	end

	// toggles once per complete header so the system side can trust cmd_q
	always_ff @(posedge sck or posedge srst)
	begin
		if (srst)
			cmdTgl_q <= 1'b0;
		else if (!csN && cnt_q == HDR_LAST)
			cmdTgl_q <= !cmdTgl_q;
	end

	always_ff @(posedge sck or posedge csN)
	begin
		if (csN)
		begin
			busyS1_q <= 1'b0;
			busyS2_q <= 1'b0;
		end
		else
		begin
			busyS1_q <= busy_q;
			busyS2_q <= busyS1_q;
		end
	end

	always_ff @(posedge sck)
	begin
		if (wrStb)
		begin
			bufMem[bufOf(op)][wAddr] <= {wsh_q, si};
			wptr_q <= (wAddr >= LAST_OFF) ? 10'd0 : wAddr + 10'd1;
		end
	end

	// output side changes on the falling edge so modes 0 and 3 both work
	always_ff @(negedge sck or posedge csN)
	begin
		if (csN)
		begin
			rdStarted_q <= 1'b0;
			rdPtr_q <= 10'd0;
			obit_q <= 3'd0;
			obyte_q <= 7'd0;
			soOut_q <= 1'b0;
		end
		else if (rdActive)
		begin
			obit_q <= obit_q + 3'd1;
			if (obit_q == 3'd0)
			begin
				rdStarted_q <= 1'b1;
				soOut_q <= rdByte[7];
				obyte_q <= rdByte[6:0];
				rdPtr_q <= (rdOff >= LAST_OFF) ? 10'd0 : rdOff + 10'd1;
			end
			else
			begin
				soOut_q <= obyte_q[6];
				obyte_q <= {obyte_q[5:0], 1'b0};
			end
		end
	end

	assign soOut = soOut_q;
	assign soOeN = csN || !rdStarted_q;

	// system clock side
	logic csS1_q, csS2_q, csS3_q;
	logic tglS1_q, tglS2_q, tglSeen_q;
	sfp_seq_type state_q;
	logic [TMR_W-1:0] tmr_q;
	logic progOn_q;
	logic [9:0] progIdx_q;
	logic [12:0] page_q;
	logic eraseStb_q, eraseBlk_q, progValid_q;
	logic [9:0] progOff_q;
	logic [7:0] progByte_q;

	logic csRise, isEP, isPO, isPE, isBE, launch;
	assign csRise = csS2_q && !csS3_q;
	assign isEP = (op == OP_BUF1_EP) || (op == OP_BUF2_EP)
		|| (op == OP_BUF1_WP) || (op == OP_BUF2_WP);
	assign isPO = (op == OP_BUF1_PR) || (op == OP_BUF2_PR);
	assign isPE = (op == OP_PAGE_ER);
	assign isBE = (op == OP_BLOCK_ER);
	// cmd_q is stable once the frame has ended, so it is read directly here
	assign launch = ce && csRise && tglS2_q != tglSeen_q && !busy_q
		&& (isEP || isPO || isPE || isBE);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			csS1_q <= 1'b1;
			csS2_q <= 1'b1;
			csS3_q <= 1'b1;
			tglS1_q <= 1'b0;
			tglS2_q <= 1'b0;
			tglSeen_q <= 1'b0;
		end
		else if (ce)
		begin
			csS1_q <= csN;
			csS2_q <= csS1_q;
			csS3_q <= csS2_q;
			tglS1_q <= cmdTgl_q;
			tglS2_q <= tglS1_q;
			if (csRise)
				tglSeen_q <= tglS2_q;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_q <= SEQ_IDLE;
			busy_q <= 1'b0;
			busyBuf_q <= 1'b0;
			tmr_q <= '0;
			page_q <= 13'd0;
			eraseStb_q <= 1'b0;
			eraseBlk_q <= 1'b0;
		end
		else if (ce)
		begin
			eraseStb_q <= 1'b0;
			case (state_q)
				SEQ_IDLE:
				begin
					if (launch)
					begin
						state_q <= SEQ_RUN;
						busy_q <= 1'b1;
						busyBuf_q <= bufOf(op);
						eraseStb_q <= isEP || isPE || isBE;
						eraseBlk_q <= isBE;
						page_q <= isBE ? {cmd_q[PAGE_MSB:BLOCK_LSB], 3'd0}
							: cmd_q[PAGE_MSB:PAGE_LSB];
						if (isEP)
							tmr_q <= TMR_W'(ERASE_PROG_CYC - 1);
						else if (isPO)
							tmr_q <= TMR_W'(PROG_ONLY_CYC - 1);
						else if (isPE)
							tmr_q <= TMR_W'(PAGE_ERASE_CYC - 1);
						else
							tmr_q <= TMR_W'(BLOCK_ERASE_CYC - 1);
					end
				end
				SEQ_RUN:
				begin
					if (tmr_q == '0)
					begin
						state_q <= SEQ_IDLE;
						busy_q <= 1'b0;
					end
					else
						tmr_q <= tmr_q - 1'b1;
				end
				default:
				begin
					state_q <= SEQ_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// program data follows the launch (after the erase strobe when there is one), one buffer byte per cycle
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			progOn_q <= 1'b0;
			progIdx_q <= 10'd0;
			progValid_q <= 1'b0;
			progOff_q <= 10'd0;
			progByte_q <= 8'h00;
		end
		else if (ce)
		begin
			progValid_q <= progOn_q;
			if (progOn_q)
			begin
				progOff_q <= progIdx_q;
				progByte_q <= bufMem[busyBuf_q][progIdx_q];
				progIdx_q <= progIdx_q + 10'd1;
				if (progIdx_q == LAST_OFF)
					progOn_q <= 1'b0;
			end
			else if (launch && (isEP || isPO))
			begin
				progOn_q <= 1'b1;
				progIdx_q <= 10'd0;
			end
		end
	end

	assign rdyBusyN = !busy_q;
	assign statusByte = {!busy_q, 7'd0};
	assign arrayEraseStb = eraseStb_q;
	assign arrayEraseBlock = eraseBlk_q;
	assign arrayErasePage = page_q;
	assign arrayProgValid = progValid_q;
	assign arrayProgPage = page_q;
	assign arrayProgOffset = progOff_q;
	assign arrayProgByte = progByte_q;

	launchBusy_a: assert property (@(posedge sys_clk) disable iff (srst)
		launch |=> !rdyBusyN) else $error("busy not raised after launch");
	statusRdy_a: assert property (@(posedge sys_clk) disable iff (srst)
		statusByte[STAT_RDY_BIT] == rdyBusyN) else $error("status bit 7 wrong");
	pageErase_a: assert property (@(posedge sys_clk) disable iff (srst)
		launch && isPE |=> arrayEraseStb && !arrayEraseBlock)
		else $error("page erase strobe missing");
	blockAlign_a: assert property (@(posedge sys_clk) disable iff (srst)
		arrayEraseStb && arrayEraseBlock |-> arrayErasePage[2:0] == 3'd0)
		else $error("block erase page not aligned");
	noErase_a: assert property (@(posedge sys_clk) disable iff (srst)
		launch && isPO |=> !arrayEraseStb) else $error("erase on program only");
	progStart_a: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(arrayProgValid) |-> arrayProgOffset == 10'd0 && !rdyBusyN)
		else $error("program stream start wrong");
	busyHold_a: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(rdyBusyN) |-> !rdyBusyN [*8]) else $error("busy dropped early");
	rdWrap_a: assert property (@(negedge sck) disable iff (csN)
		rdActive && obit_q == 3'd0 && rdOff == LAST_OFF |=> rdPtr_q == 10'd0)
		else $error("read pointer did not wrap");
	hdrQuiet_a: assert property (@(posedge sck) disable iff (csN)
		cnt_q < BUF_RD_START |-> soOeN) else $error("output driven in header");

	pageRd_c: cover property (@(negedge sck) disable iff (csN)
		isPageRd && rdActive && rdStarted_q);
	bufWr_c: cover property (@(posedge sck) disable iff (csN) wrStb);
	blkEr_c: cover property (@(posedge sys_clk) disable iff (srst)
		launch && isBE);
	prog_c: cover property (@(posedge sys_clk) disable iff (srst)
		arrayProgValid && arrayProgOffset == LAST_OFF);
endmodule

// *** dv/sfp_host_model.sv ***
// host-side serial master model for the flash link
`timescale 1ns/1ps
module sfp_host_model (
	output logic sck,
	output logic csN,
	output logic si,
	input wire logic soOut,
	input wire logic soOeN
);
	logic [7:0] rd [0:1023];
	logic oeBad;
	initial
	begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
		oeBad = 1'b0;
	end
	// clock stands low between frames; data sampled just before rising
	task automatic frame(input logic [7:0] op, input logic [23:0] ad,
		input int dum, input int nb, input logic [7:0] sd, input bit isRd);
		logic [31:0] hdr;
		logic [7:0] b;
		int i;
		int d;
		hdr = {op, ad};
		csN = 1'b0;
		#6;
		for (i = 0; i < 32 + dum + nb * 8; i++)
		begin
			d = i - 32 - dum;
			b = sd + 8'(d / 8);
			si = (i < 32) ? hdr[31 - i] : (d < 0) ? ~si : b[7 - d % 8];
			#6;
			if (isRd && d >= 0)
			begin
				rd[d / 8][7 - d % 8] = soOut;
				if (soOeN !== 1'b0)
					oeBad = 1'b1;
			end
			sck = 1'b1;
			#6 sck = 1'b0;
		end
		#6 csN = 1'b1;
		// released input no longer shows the last bit
		si = ~si;
		// deselect spans two system clocks so every frame end is seen
		#250;
	endtask
endmodule

// *** dv/tb_serial_flash_page_buffer_ops.sv ***
// self-checking bench: buffer traffic, page reads and self-timed ops
`timescale 1ns/1ps
module tb_serial_flash_page_buffer_ops;
	import sfp_pkg::*;
	localparam int EPC = 640;
	localparam int POC = 610;
	localparam int PEC = 600;
	localparam int BEC = 620;
	// erase precedes each program-only op on the same page
	localparam logic [7:0] OPS [8] = '{OP_PAGE_ER, OP_BUF1_PR, OP_BLOCK_ER,
		OP_BUF2_PR, OP_BUF1_EP, OP_BUF2_EP, OP_BUF1_WP, OP_BUF2_WP};
	localparam int KIND [8] = '{0, 1, 2, 1, 3, 3, 3, 3};
	localparam int BUFI [8] = '{0, 0, 0, 1, 0, 1, 0, 1};
	localparam int CYC [4] = '{PEC, POC, BEC, EPC};
	logic sys_clk, srst, sck, csN, si, soOut, soOeN, rdyBusyN;
	logic [7:0] statusByte, arrayProgByte, sh [2][528], progMem [528];
	logic [12:0] arrayRdPage, arrayErasePage, arrayProgPage, erPage, pg;
	logic [9:0] arrayRdOffset, arrayProgOffset;
	logic arrayEraseStb, arrayEraseBlock, arrayProgValid, erBlk, offBad;
	int fails, n_compared, busyCnt, eraseCnt, progCnt;
	wire [7:0] arrayRdData = arrayRdPage[7:0] ^ arrayRdOffset[7:0] ^ 8'h5a;
	sfp_host_model host_u (.sck(sck), .csN(csN), .si(si), .soOut(soOut),
		.soOeN(soOeN));
	sfp_flash_seq #(.ERASE_PROG_CYC(EPC), .PROG_ONLY_CYC(POC),
		.PAGE_ERASE_CYC(PEC), .BLOCK_ERASE_CYC(BEC)) dut_u (
		.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .sck(sck), .csN(csN),
		.si(si), .soOut(soOut), .soOeN(soOeN), .rdyBusyN(rdyBusyN),
		.statusByte(statusByte), .arrayRdPage(arrayRdPage),
		.arrayRdOffset(arrayRdOffset), .arrayRdData(arrayRdData),
		.arrayEraseStb(arrayEraseStb), .arrayEraseBlock(arrayEraseBlock),
		.arrayErasePage(arrayErasePage), .arrayProgValid(arrayProgValid),
		.arrayProgPage(arrayProgPage), .arrayProgOffset(arrayProgOffset),
		.arrayProgByte(arrayProgByte));
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk)
	begin
		if (rdyBusyN === 1'b0)
			busyCnt++;
		if (arrayEraseStb === 1'b1)
		begin
			eraseCnt++;
			erPage = arrayErasePage;
			erBlk = arrayEraseBlock;
		end
		if (arrayProgValid === 1'b1)
		begin
			if (progCnt < 528)
			begin
				if (arrayProgOffset !== 10'(progCnt) || arrayProgPage !== pg)
					offBad = 1'b1;
				progMem[progCnt] = arrayProgByte;
			end
			progCnt++;
		end
	end
	task automatic complete_run();
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// expected main array byte, same pattern as the array stand-in
	function automatic logic [7:0] arrByte(input logic [12:0] p,
		input int o);
		return p[7:0] ^ 8'(o % 528) ^ 8'h5a;
	endfunction
	task automatic chk(input bit ok, input string m);
		n_compared++;
		if (!ok)
		begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] op, input logic [23:0] ad, input int nb);
		logic [7:0] sd;
		int k;
		sd = 8'($urandom);
		host_u.frame(op, ad, 0, nb, sd, 1'b0);
		for (k = 0; k < nb; k++)
			sh[op == OP_BUF2_WR || op == OP_BUF2_WP][(ad[9:0] + k) % 528] =
				sd + 8'(k);
	endtask
	task automatic rdb(input logic [7:0] op, input logic [9:0] o, input int nb);
		int k;
		int bad;
		logic [7:0] e;
		bad = 0;
		host_u.oeBad = 1'b0;
		host_u.frame(op, {1'b0, pg, o}, op == OP_PAGE_RD ? 32 : 8, nb,
			8'h00, 1'b1);
		#2;
		for (k = 0; k < nb; k++)
		begin
			e = op == OP_PAGE_RD ? arrByte(pg, o + k)
				: sh[op == OP_BUF2_RD][(o + k) % 528];
			bad += int'(host_u.rd[k] !== e);
		end
		chk(bad == 0 && !host_u.oeBad && soOeN === 1'b1, "read data");
	endtask
	initial
	begin
		#1500000;
		fails++;
		complete_run();
	end
	initial
	begin
		int i;
		int w;
		int k;
		int bad;
		srst = 1'b1;
		void'($urandom(55));
		repeat (4) @(negedge sys_clk);
		srst = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(rdyBusyN === 1'b1 && statusByte === 8'h80, "reset state");
		pg = 13'($urandom);
		wr(OP_BUF1_WR, 24'd525, 530);
		wr(OP_BUF2_WR, 24'd525, 530);
		rdb(OP_BUF1_RD, 10'd525, 5);
		rdb(OP_BUF2_RD, 10'd526, 3);
		rdb(OP_PAGE_RD, 10'd526, 4);
		for (i = 0; i < 8; i++)
		begin
			busyCnt = 0;
			eraseCnt = 0;
			progCnt = 0;
			offBad = 1'b0;
			if (i > 5)
				wr(OPS[i], {1'b0, pg, 10'(300 + $urandom % 200)}, 3);
			else
				host_u.frame(OPS[i], {1'b0, pg, 10'h0}, 0, 0, 8'h00, 1'b0);
			for (w = 0; w < 50 && rdyBusyN !== 1'b0; w++)
				@(negedge sys_clk);
			chk(rdyBusyN === 1'b0 && statusByte === 8'h00, "busy");
			if (i == 4)
			begin
				host_u.frame(OP_BUF1_WR, 24'd100, 0, 1, ~sh[0][100], 1'b0);
				host_u.frame(OP_BUF2_EP, 24'd0, 0, 0, 8'h00, 1'b0);
			end
			for (w = 0; w < 700 && rdyBusyN !== 1'b1; w++)
				@(negedge sys_clk);
			bad = 0;
			for (k = 0; k < 528; k++)
				bad += int'(progMem[k] !== sh[BUFI[i]][k]);
			chk(busyCnt == CYC[KIND[i]], "busy length");
			chk(eraseCnt == int'(KIND[i] != 1) && (KIND[i] == 1 ||
				erPage === (KIND[i] == 2 ? {pg[12:3], 3'b000} : pg) &&
				erBlk === (KIND[i] == 2)), "erase");
			chk(KIND[i] % 2 == 1 ? progCnt == 528 && !offBad && bad == 0
				: progCnt == 0, "program");
		end
		complete_run();
	end
endmodule
